// ---- depc_pkg.sv ----
// Shared constants and types of the dual event pulse counter
package depc_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [9:0] IDX_FIRST_LOW = 10'h2f8;
   localparam logic [9:0] IDX_FIRST_HIGH = 10'h2f9;
   localparam logic [9:0] IDX_SECOND_LOW = 10'h2fa;
   localparam logic [9:0] IDX_SECOND_HIGH = 10'h2fb;
   localparam logic [9:0] IDX_CONTROL = 10'h2fc;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Control field positions
   localparam int BIT_FIRST_CLEAR = 0;
   localparam int BIT_SECOND_CLEAR = 1;
   localparam int BIT_RUN = 2;
   localparam int BIT_MODE = 3;

   // Values after reset
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic RUN_RESET = 1'b0;
   localparam logic MODE_RESET = 1'b0;

   // Noise rejector divider: oscillator divided by 16 or by 128
   localparam int NR_DIV_DEFAULT = 16;

   // Count mode carried in the control word
   typedef enum logic {
      DEPC_PHASE = 1'b0,
      DEPC_SEPARATE = 1'b1
   } depc_mode_t;

   // Software control word
   typedef struct packed {
      depc_mode_t mode;
      logic run;
   } depc_ctrl_t;

endpackage : depc_pkg

// ---- depc_noise_filter.sv ----
// Noise rejector for one pulse input
`timescale 1ns/10ps
`default_nettype none
module depc_noise_filter (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sample strobe from the rejector clock
   input wire logic sample,
   // Raw pin and cleaned level
   input wire logic pin,
   output logic level
);

   logic last; // Level seen at the previous sample

   // Keep the previous sample of the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 1'b0;
      end else if (sample) begin
         last <= pin;
      end
   end

   // Accept a level only when two samples agree, so a glitch
   // shorter than one rejector period never passes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b0;
      end else if (sample && (pin == last)) begin
         level <= pin;
      end
   end

endmodule : depc_noise_filter
`default_nettype wire

// ---- depc_counter.sv ----
// Dual event pulse counter with APB register access
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R01: First counter nibbles read-only, reset zero
// R02: Second counter nibbles read-only, reset zero
// R03: Writing D0 one clears first counter
// R04: Writing D1 one clears second counter
// R05: Run bit D2 readable, starts counting, resets zero
// R06: Stopped counters ignore pulses; pins stay readable
// R07: Mode D3 one selects separate mode
// R08: Mode zero selects phase detection routing
// R09: Run change applies at rejector clock fall
// R10: Software reads counters repeatedly until agreeing
// R11: Each counter is eight-bit binary up-counter
// R12: Input A leading feeds second counter
// R13: Separate mode: A first, B second
// R14: Rejector clock is oscillator by 16/128
// R15: Counters wrap to zero, no overflow flag
module depc_counter #(
   parameter int NR_DIV = depc_pkg::NR_DIV_DEFAULT
) (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [depc_pkg::ADDR_W-1:0] paddr,
   input wire logic [depc_pkg::DATA_W-1:0] pwdata,
   // APB answer
   output logic [depc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Low-speed oscillator, sampled as a plain level
   input wire logic low_speed_osc_clock,
   // Pulse inputs
   input wire logic pulse_input_a,
   input wire logic pulse_input_b,
   // Pin levels for the general input port
   output logic pin_level_a,
   output logic pin_level_b
);

   // Divider width for the rejector clock
   localparam int DIV_W = $clog2(NR_DIV);

   // Register state
   depc_pkg::depc_ctrl_t ctrl; // Mode and written run bit
   logic run_active; // Run state as seen by the counters
   logic [7:0] first_count; // First counter
   logic [7:0] second_count; // Second counter

   // Rejector clock
   logic osc_prev; // Oscillator level one cycle ago
   logic osc_rise; // Oscillator rising edge
   logic [DIV_W-1:0] div_cnt; // Oscillator edge divider
   logic nr_clk; // Rejector clock level
   logic nr_prev; // Rejector clock one cycle ago
   logic nr_rise; // Sample point of the filters
   logic nr_fall; // Point where run changes apply

   // Filtered inputs and edges
   logic [1:0] raw_pins; // Both raw pins
   logic [1:0] filt; // Filtered levels, bit 0 is input A
   logic [1:0] filt_prev; // Filtered levels one cycle ago
   logic a_rise; // Filtered rising edge of input A
   logic b_rise; // Filtered rising edge of input B

   // Bus decode
   logic setup_rd; // Read in its setup cycle
   logic access_wr; // Write at its completing edge
   logic wr_ctrl; // Write to the control register
   logic first_clear; // Clear strobe for the first counter
   logic second_clear; // Clear strobe for the second counter
   logic mapped; // Address hits a register
   logic [depc_pkg::DATA_W-1:0] next_rdata; // Read mux output

   // Counter steering
   logic inc_first; // Add one to the first counter
   logic inc_second; // Add one to the second counter

   // Match an address against a register index
   function automatic logic reg_hit(
      input logic [depc_pkg::ADDR_W-1:0] addr,
      input logic [9:0] idx
   );
      reg_hit = (addr == {idx, 2'b00});
   endfunction : reg_hit

   // The slave never waits
   assign pready = 1'b1;

   // Request decode
   assign setup_rd = psel && !penable && !pwrite;
   assign access_wr = psel && penable && pwrite;
   assign wr_ctrl = access_wr && reg_hit(paddr, depc_pkg::IDX_CONTROL);
   assign first_clear = wr_ctrl && pwdata[depc_pkg::BIT_FIRST_CLEAR]; // R03
   assign second_clear = wr_ctrl && pwdata[depc_pkg::BIT_SECOND_CLEAR]; // R04

   // Any of the five registers
   assign mapped = reg_hit(paddr, depc_pkg::IDX_FIRST_LOW)
      || reg_hit(paddr, depc_pkg::IDX_FIRST_HIGH)
      || reg_hit(paddr, depc_pkg::IDX_SECOND_LOW)
      || reg_hit(paddr, depc_pkg::IDX_SECOND_HIGH)
      || reg_hit(paddr, depc_pkg::IDX_CONTROL);

   // Read mux; counter nibbles sit in the low bits
   always_comb begin
      next_rdata = '0;
      if (reg_hit(paddr, depc_pkg::IDX_FIRST_LOW)) begin
         next_rdata[3:0] = first_count[3:0]; // R01
      end else if (reg_hit(paddr, depc_pkg::IDX_FIRST_HIGH)) begin
         next_rdata[3:0] = first_count[7:4]; // R01
      end else if (reg_hit(paddr, depc_pkg::IDX_SECOND_LOW)) begin
         next_rdata[3:0] = second_count[3:0]; // R02
      end else if (reg_hit(paddr, depc_pkg::IDX_SECOND_HIGH)) begin
         next_rdata[3:0] = second_count[7:4]; // R02
      end else if (reg_hit(paddr, depc_pkg::IDX_CONTROL)) begin
         // Clear bits always read as zero
         next_rdata[depc_pkg::BIT_RUN] = ctrl.run; // R05
         next_rdata[depc_pkg::BIT_MODE] = ctrl.mode; // R07
      end
   end

   // Read data is captured in the setup cycle, so the count can
   // move one cycle before the access edge; software rereads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup_rd) begin
         prdata <= next_rdata;
      end
   end

   // Error answer for an unmapped address, either direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= !mapped;
      end
   end

   // Control register; writes to counter nibbles are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl.run <= depc_pkg::RUN_RESET; // R05
         ctrl.mode <= depc_pkg::DEPC_PHASE; // R07
      end else if (wr_ctrl) begin
         ctrl.run <= pwdata[depc_pkg::BIT_RUN]; // R05
         ctrl.mode <= depc_mode_cast(pwdata[depc_pkg::BIT_MODE]); // R07
      end
   end

   // Mode bit to mode type
   function automatic depc_pkg::depc_mode_t depc_mode_cast(
      input logic b
   );
      depc_mode_cast = b ? depc_pkg::DEPC_SEPARATE : depc_pkg::DEPC_PHASE;
   endfunction : depc_mode_cast

   // Oscillator edge detect; the oscillator is far slower than pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= low_speed_osc_clock;
      end
   end
   assign osc_rise = low_speed_osc_clock && !osc_prev;

   // Divide oscillator edges down to the rejector clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= '0;
      end else if (osc_rise) begin
         div_cnt <= div_cnt + 1'b1; // R14
      end
   end
   assign nr_clk = div_cnt[DIV_W-1]; // R14

   // Rejector clock edges as one-cycle strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nr_prev <= 1'b0;
      end else begin
         nr_prev <= nr_clk;
      end
   end
   assign nr_rise = nr_clk && !nr_prev;
   assign nr_fall = !nr_clk && nr_prev;

   // Written run bit reaches the counters only at a falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_active <= depc_pkg::RUN_RESET;
      end else if (nr_fall) begin
         run_active <= ctrl.run; // R09
      end
   end

   // Pins stay visible to the input port even while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_level_a <= 1'b0;
         pin_level_b <= 1'b0;
      end else begin
         pin_level_a <= pulse_input_a; // R06
         pin_level_b <= pulse_input_b; // R06
      end
   end

   // One noise rejector per input
   assign raw_pins = {pulse_input_b, pulse_input_a};
   for (genvar i = 0; i < 2; i++) begin : g_filter
      depc_noise_filter u_filter (
         .pclk(pclk),
         .presetn(presetn),
         .sample(nr_rise), // R14
         .pin(raw_pins[i]),
         .level(filt[i])
      );
   end

   // Filtered levels one cycle ago, for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_prev <= '0;
      end else begin
         filt_prev <= filt;
      end
   end
   assign a_rise = filt[0] && !filt_prev[0];
   assign b_rise = filt[1] && !filt_prev[1];

   // Steer pulses; in phase mode the lagging edge counts, and both
   // edges in one cycle give no phase and no count
   always_comb begin
      inc_first = 1'b0;
      inc_second = 1'b0;
      if (run_active) begin // R06
         case (ctrl.mode)
            depc_pkg::DEPC_SEPARATE: begin
               inc_first = a_rise; // R13
               inc_second = b_rise; // R13
            end
            depc_pkg::DEPC_PHASE: begin
               // B already high when A rises: B leads
               inc_first = a_rise && filt_prev[1]; // R08
               // A already high when B rises: A leads
               inc_second = b_rise && filt_prev[0]; // R12
            end
            default: begin
               inc_first = 1'b0;
               inc_second = 1'b0;
            end
         endcase
      end
   end

   // First counter; a clear beats a pulse in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_count <= depc_pkg::COUNT_RESET; // R01
      end else if (first_clear) begin
         first_count <= depc_pkg::COUNT_RESET; // R03
      end else if (inc_first) begin
         first_count <= first_count + 8'h01; // R11 R15
      end
   end

   // Second counter; same priority as the first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_count <= depc_pkg::COUNT_RESET; // R02
      end else if (second_clear) begin
         second_count <= depc_pkg::COUNT_RESET; // R04
      end else if (inc_second) begin
         second_count <= second_count + 8'h01; // R11 R15
      end
   end

   // Checks on the logic above
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // First counter high nibble reads back what the counter held
   AST_FIRST_READ: assert property ( // R01
      setup_rd && reg_hit(paddr, depc_pkg::IDX_FIRST_HIGH)
      |=> prdata == {28'h0, $past(first_count[7:4])})
      else $error("first counter high nibble misread");

   // Second counter low nibble reads back what the counter held
   AST_SECOND_READ: assert property ( // R02
      setup_rd && reg_hit(paddr, depc_pkg::IDX_SECOND_LOW)
      |=> prdata == {28'h0, $past(second_count[3:0])})
      else $error("second counter low nibble misread");

   // Writes to the first counter low nibble never load it
   AST_RO_WRITE: assert property ( // R01
      access_wr && reg_hit(paddr, depc_pkg::IDX_FIRST_LOW) && !inc_first
      |=> first_count == $past(first_count))
      else $error("counter changed by a bus write");

   // Clear bit empties the first counter next cycle
   AST_FIRST_CLEAR: assert property ( // R03
      wr_ctrl && pwdata[0] |=> first_count == 8'h00)
      else $error("first counter not cleared");

   // Clear bit empties the second counter next cycle
   AST_SECOND_CLEAR: assert property ( // R04
      wr_ctrl && pwdata[1] |=> second_count == 8'h00)
      else $error("second counter not cleared");

   // Control reads show run and mode, clears as zero
   AST_CTRL_READ: assert property ( // R05
      setup_rd && reg_hit(paddr, depc_pkg::IDX_CONTROL)
      |=> prdata[1:0] == 2'b00 && prdata[2] == $past(ctrl.run)
      && prdata[3] == $past(ctrl.mode))
      else $error("control register misread");

   // Stopped first counter holds still
   AST_STOP_HOLD: assert property ( // R06
      !run_active && !first_clear |=> $stable(first_count))
      else $error("counter moved while stopped");

   // Run state moves only at a rejector clock fall
   AST_RUN_SYNC: assert property ( // R09
      $changed(run_active) |-> $past(nr_fall)
      && run_active == $past(ctrl.run))
      else $error("run state changed off the falling edge");

   // Each accepted pulse adds exactly one to the second counter, wrapping at the top
   AST_INCREMENT: assert property ( // R11
      inc_second && !second_clear
      |=> second_count == $past(second_count) + 8'h01)
      else $error("second counter did not step by one");

   // Phase mode: A leading steps only the second counter
   AST_PHASE_ROUTE: assert property ( // R12
      run_active && ctrl.mode == depc_pkg::DEPC_PHASE && b_rise
      && filt_prev[0] && !a_rise && !second_clear && !first_clear
      |=> second_count == $past(second_count) + 8'h01
      && first_count == $past(first_count))
      else $error("phase routing wrong");

   // Separate mode: A steps the first counter
   AST_SEPARATE_ROUTE: assert property ( // R13
      run_active && ctrl.mode == depc_pkg::DEPC_SEPARATE && a_rise
      && !first_clear |=> first_count == $past(first_count) + 8'h01)
      else $error("separate routing wrong");

   // Rejector clock falls only as the divider wraps
   AST_DIVIDER: assert property ( // R14
      nr_fall |-> div_cnt == '0)
      else $error("rejector clock fall off the divider wrap");

endmodule : depc_counter
`default_nettype wire

// ---- depc_pulse_src.sv ----
// Behavioural pulse source that drives both counter input pins
`timescale 1ns/10ps
`default_nettype none
module depc_pulse_src #(
   parameter int HALF = 144, // High and low time, over two rejector periods
   parameter int SHIFT = 72 // Phase offset, over one rejector period
) (
   // Clock
   input wire logic pclk,
   // Request: kind 0 A, 1 B, 2 both, 3 A leads, 4 B leads
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic [8:0] count,
   output logic busy,
   // Pulse pins, always driven, so never left floating
   output logic pulse_input_a,
   output logic pulse_input_b
);
   logic fa, fb, sa, sb; // Lines rising in the first and second phase
   initial begin
      busy = 1'b0;
      pulse_input_a = 1'b0;
      pulse_input_b = 1'b0;
   end
   // Sequencer; the lagging line stays high after the leader falls
   always begin
      @(posedge pclk);
      if (go) begin
         fa = (kind == 3'h0 || kind == 3'h2 || kind == 3'h3);
         fb = (kind == 3'h1 || kind == 3'h2 || kind == 3'h4);
         sa = (kind == 3'h4);
         sb = (kind == 3'h3);
         busy <= 1'b1;
         for (int i = 0; i < count; i++) begin
            pulse_input_a <= fa;
            pulse_input_b <= fb;
            if (sa | sb) begin
               repeat (SHIFT) @(posedge pclk);
               pulse_input_a <= fa | sa;
               pulse_input_b <= fb | sb;
            end
            repeat ((sa | sb) ? HALF - SHIFT : HALF) @(posedge pclk);
            pulse_input_a <= sa;
            pulse_input_b <= sb;
            if (sa | sb) begin
               repeat (SHIFT) @(posedge pclk);
               pulse_input_a <= 1'b0;
               pulse_input_b <= 1'b0;
            end
            repeat (HALF) @(posedge pclk);
         end
         busy <= 1'b0;
      end
   end
endmodule : depc_pulse_src
`default_nettype wire

// ---- depc_counter_tb.sv ----
// Self-checking testbench of the dual event pulse counter
`timescale 1ns/10ps
`default_nettype none
module depc_counter_tb;
   logic pclk, presetn, psel, penable, pwrite; // Bus master side
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er;
   logic osc, pa, pb, lvl_a, lvl_b, prev_a, prev_b; // Pins and oscillator
   logic go, busy; // Pulse source request
   logic [2:0] kind;
   logic [8:0] cnt;
   logic [7:0] cv; // Counter value read back
   int err_total, total_checks, rises_a, rises_b;

   depc_counter #(.NR_DIV(16)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_speed_osc_clock(osc),
      .pulse_input_a(pa), .pulse_input_b(pb),
      .pin_level_a(lvl_a), .pin_level_b(lvl_b));
   depc_pulse_src SRC (.pclk(pclk), .go(go), .kind(kind), .count(cnt),
      .busy(busy), .pulse_input_a(pa), .pulse_input_b(pb));

   // 250 MHz bus clock
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;
   // Oscillator of four bus cycles, offset so its phase is unrelated
   initial begin
      osc = 1'b0;
      #1;
      forever #8 osc = ~osc;
   end
   // Rising edges of the pin copies, which must follow even when stopped
   always @(posedge pclk) begin
      if (lvl_a === 1'b1 && prev_a === 1'b0) rises_a++;
      if (lvl_b === 1'b1 && prev_b === 1'b0) rises_b++;
      prev_a <= lvl_a;
      prev_b <= lvl_b;
   end

   // Word comparison
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Single flag comparison
   task automatic chk_bit(input string what, input logic exp,
                          input logic got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   // Bus access; the request holds until pready is seen high, and only
   // the watchdog ends a wait that never completes
   task automatic apb(input logic wr, input logic [9:0] idx,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads one counter as two nibbles, up to four pairs of passes, until two passes agree
   task automatic rd_count(input logic [9:0] lo, output logic [7:0] v);
      logic [7:0] a, b;
      logic [31:0] q;
      logic e;
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, lo, 32'h0, q, e);
         a[3:0] = q[3:0];
         apb(1'b0, lo + 10'h001, 32'h0, q, e);
         a[7:4] = q[3:0];
         apb(1'b0, lo, 32'h0, q, e);
         b[3:0] = q[3:0];
         apb(1'b0, lo + 10'h001, 32'h0, q, e);
         b[7:4] = q[3:0];
         if (a === b) break;
      end
      v = b;
   endtask : rd_count

   // Both counters against expectations
   task automatic chk_counts(input logic [7:0] e1, input logic [7:0] e2);
      rd_count(depc_pkg::IDX_FIRST_LOW, cv);
      chk("first count", {24'h0, e1}, {24'h0, cv});
      rd_count(depc_pkg::IDX_SECOND_LOW, cv);
      chk("second count", {24'h0, e2}, {24'h0, cv});
   endtask : chk_counts

   // Hands a burst to the pulse source and waits for it to finish
   task automatic pulses(input logic [2:0] k, input logic [8:0] n);
      @(posedge pclk);
      go <= 1'b1;
      kind <= k;
      cnt <= n;
      do @(posedge pclk); while (busy !== 1'b1);
      go <= 1'b0;
      while (busy !== 1'b0) @(posedge pclk);
   endtask : pulses

   // Control write shorthand
   task automatic ctl(input logic [31:0] d);
      apb(1'b1, depc_pkg::IDX_CONTROL, d, rd, er);
   endtask : ctl

   // Counts, verdict and end of run
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // Watchdog: the tests need roughly 80000 cycles
   initial begin
      repeat (95000) @(posedge pclk);
      err_total++;
      finish_test;
   end

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      go = 1'b0;
      kind = 3'h0;
      cnt = 9'h000;
      err_total = 0;
      total_checks = 0;
      rises_a = 0;
      rises_b = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, depc_pkg::IDX_FIRST_LOW + 10'(i), 32'h0, rd, er);
         chk("reset value", 32'h0, rd);
         chk_bit("mapped error", 1'b0, er);
      end
      apb(1'b0, 10'h2fd, 32'h0, rd, er);
      chk_bit("unmapped error", 1'b1, er);
      $display("test reset done");
      ctl(32'h8);
      pulses(3'h0, 9'd2);
      chk_counts(8'h00, 8'h00);
      chk("pin rises", 32'd2, 32'(rises_a));
      $display("test stopped done");
      ctl(32'hc);
      apb(1'b0, depc_pkg::IDX_CONTROL, 32'h0, rd, er);
      chk("control", 32'hc, rd);
      // Run takes hold only at a rejector clock fall, 64 cycles apart
      repeat (160) @(posedge pclk);
      pulses(3'h0, 9'd3);
      pulses(3'h1, 9'd2);
      chk_counts(8'h03, 8'h02);
      for (int i = 0; i < 4; i++)
         apb(1'b1, depc_pkg::IDX_FIRST_LOW + 10'(i), 32'hf, rd, er);
      chk_counts(8'h03, 8'h02);
      $display("test separate done");
      ctl(32'hd);
      chk_counts(8'h00, 8'h02);
      ctl(32'hc);
      chk_counts(8'h00, 8'h02);
      ctl(32'he);
      chk_counts(8'h00, 8'h00);
      $display("test clear done");
      ctl(32'h4);
      pulses(3'h3, 9'd2);
      chk_counts(8'h00, 8'h02);
      pulses(3'h4, 9'd3);
      chk_counts(8'h03, 8'h02);
      $display("test phase done");
      ctl(32'hf);
      pulses(3'h2, 9'd258);
      chk_counts(8'h02, 8'h02);
      $display("test wrap done");
      ctl(32'h8);
      repeat (160) @(posedge pclk);
      pulses(3'h0, 9'd1);
      chk_counts(8'h02, 8'h02);
      chk("pin rises", 32'd269, 32'(rises_a));
      chk("pin b rises", 32'd265, 32'(rises_b));
      $display("test stop done");
      finish_test;
   end
endmodule : depc_counter_tb
`default_nettype wire
